// File: pkg/vrd_consts.vh
`ifndef VRD_CONSTS_VH
`define VRD_CONSTS_VH

// Register offsets, low byte of the channel address
`define VRD_OFS_RDI_PLM 8'hC9
`define VRD_OFS_RDI_TIM_UNEQ 8'hCA
`define VRD_OFS_RDI_LOP_AIS 8'hCB
`define VRD_OFS_OH_CLK_CTRL 8'hCF

// Reset values
`define VRD_RST_RDI_PLM 8'h00
`define VRD_RST_RDI_TIM_UNEQ 8'hC0
`define VRD_RST_RDI_LOP_AIS 8'hC0
`define VRD_RST_OH_CLK_CTRL 8'h00

// Field positions of the defect control registers; the PLM register keeps only the low code and enable
`define VRD_HI_CODE_MSB 7
`define VRD_HI_CODE_LSB 5
`define VRD_HI_EN_BIT 4
`define VRD_LO_CODE_MSB 3
`define VRD_LO_CODE_LSB 1
`define VRD_LO_EN_BIT 0

// Writable part of the sparse registers
`define VRD_PLM_WR_MASK 8'h0F
`define VRD_CLK_WR_MASK 8'h0F

// RDI bit field inside the G1 byte, and its non-alarm value
`define VRD_G1_RDI_MSB 3
`define VRD_G1_RDI_LSB 1
`define VRD_RDI_NORMAL 3'h0

`endif

// File: verilog/vrd_path_rdi_insert_ctrl.v
`timescale 1ns/1ps
`include "vrd_consts.vh"

module vrd_path_rdi_insert_ctrl #(
   parameter DATA_W = 8
) (
   input wire clk,
   input wire reset_n,
   // Byte-wide register port
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   // Defect declarations from the receive path, levels
   input wire def_pointer_loss,
   input wire def_path_alarm,
   input wire def_unequipped,
   input wire def_trace_mismatch,
   input wire def_payload_mismatch,
   // One-cycle pulse at 19.44 MHz from the reference
   input wire ref_tick,
   output reg overhead_port_clock_out,
   // Outbound VC-3 byte stream
   input wire [DATA_W-1:0] in_data,
   input wire in_g1,
   input wire in_valid,
   output reg in_ready,
   output reg [DATA_W-1:0] out_data,
   output reg out_g1,
   output reg out_valid,
   input wire out_ready
);

   reg [7:0] rdi_ctrl_plm_q;
   reg [7:0] rdi_ctrl_tim_uneq_q;
   reg [7:0] rdi_ctrl_lop_ais_q;
   reg [7:0] overhead_port_clock_ctrl_q;
   reg [3:0] div_cnt_q;
   reg [DATA_W-1:0] skid_data_q;
   reg skid_g1_q;
   reg skid_valid_q;

   wire [3:0] overhead_clock_divider;
   wire [2:0] rdi_code;
   wire [DATA_W-1:0] ins_data;
   wire in_fire;

   // Next-state values, one per register above
   reg [7:0] rdi_ctrl_plm_d;
   reg [7:0] rdi_ctrl_tim_uneq_d;
   reg [7:0] rdi_ctrl_lop_ais_d;
   reg [7:0] overhead_port_clock_ctrl_d;
   reg [7:0] reg_rdata_d;
   reg [3:0] div_cnt_d;
   reg port_clock_d;
   reg [DATA_W-1:0] head_data_d;
   reg head_g1_d;
   reg head_valid_d;
   reg [DATA_W-1:0] skid_data_d;
   reg skid_g1_d;
   reg skid_valid_d;
   reg in_ready_d;

   // Register selects, shared by the write and read decoders
   wire sel_payload;
   wire sel_tim_uneq;
   wire sel_lop_ais;
   wire sel_clk_ctrl;

   // Fixed-priority choice of RDI code; a disabled defect is skipped
   function [2:0] pick_code;
      input [4:0] act;
      input [2:0] c_lop;
      input [2:0] c_ais;
      input [2:0] c_uneq;
      input [2:0] c_tim;
      input [2:0] c_plm;
      begin
         if (act[4]) begin
            pick_code = c_lop;
         end else if (act[3]) begin
            pick_code = c_ais;
         end else if (act[2]) begin
            pick_code = c_uneq;
         end else if (act[1]) begin
            pick_code = c_tim;
         end else if (act[0]) begin
            pick_code = c_plm;
         end else begin
            pick_code = `VRD_RDI_NORMAL;
         end
      end
   endfunction

   // Address compare; one place to change if the map ever widens
   function addr_hit;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         addr_hit = (addr == ofs);
      end
   endfunction

   // Decoded once, used by both the write and the read path
   assign sel_payload = addr_hit(reg_addr, `VRD_OFS_RDI_PLM);
   assign sel_tim_uneq = addr_hit(reg_addr, `VRD_OFS_RDI_TIM_UNEQ);
   assign sel_lop_ais = addr_hit(reg_addr, `VRD_OFS_RDI_LOP_AIS);
   assign sel_clk_ctrl = addr_hit(reg_addr, `VRD_OFS_OH_CLK_CTRL);

   // Enable gates each live declaration; no latching, so insertion
   // follows the declaration byte for byte
   assign rdi_code = pick_code({
      rdi_ctrl_lop_ais_q[`VRD_HI_EN_BIT] & def_pointer_loss,
      rdi_ctrl_lop_ais_q[`VRD_LO_EN_BIT] & def_path_alarm,
      rdi_ctrl_tim_uneq_q[`VRD_LO_EN_BIT] & def_unequipped,
      rdi_ctrl_tim_uneq_q[`VRD_HI_EN_BIT] & def_trace_mismatch,
      rdi_ctrl_plm_q[`VRD_LO_EN_BIT] & def_payload_mismatch},
      rdi_ctrl_lop_ais_q[`VRD_HI_CODE_MSB:`VRD_HI_CODE_LSB],
      rdi_ctrl_lop_ais_q[`VRD_LO_CODE_MSB:`VRD_LO_CODE_LSB],
      rdi_ctrl_tim_uneq_q[`VRD_LO_CODE_MSB:`VRD_LO_CODE_LSB],
      rdi_ctrl_tim_uneq_q[`VRD_HI_CODE_MSB:`VRD_HI_CODE_LSB],
      rdi_ctrl_plm_q[`VRD_LO_CODE_MSB:`VRD_LO_CODE_LSB]);

   // Only the G1 byte is touched; the rest of the G1 passes through
   assign ins_data = in_g1 ?
      {in_data[DATA_W-1:`VRD_G1_RDI_MSB+1], rdi_code,
       in_data[`VRD_G1_RDI_LSB-1:0]} : in_data;

   assign in_fire = in_valid & in_ready;
   assign overhead_clock_divider = overhead_port_clock_ctrl_q[3:0];

   // Next register values; a write lands on the following edge
   always @* begin
      rdi_ctrl_plm_d = rdi_ctrl_plm_q;
      rdi_ctrl_tim_uneq_d = rdi_ctrl_tim_uneq_q;
      rdi_ctrl_lop_ais_d = rdi_ctrl_lop_ais_q;
      overhead_port_clock_ctrl_d = overhead_port_clock_ctrl_q;
      if (reg_wr) begin
         if (sel_payload) begin
            // Only code and enable are kept; the rest reads zero
            rdi_ctrl_plm_d = reg_wdata & `VRD_PLM_WR_MASK;
         end else if (sel_tim_uneq) begin
            rdi_ctrl_tim_uneq_d = reg_wdata;
         end else if (sel_lop_ais) begin
            rdi_ctrl_lop_ais_d = reg_wdata;
         end else if (sel_clk_ctrl) begin
            // Upper bits are not stored, so they read back as zero
            overhead_port_clock_ctrl_d =
               reg_wdata & `VRD_CLK_WR_MASK;
         end
      end
   end

   // Control registers; reset loads the documented defaults
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdi_ctrl_plm_q <= `VRD_RST_RDI_PLM;
         rdi_ctrl_tim_uneq_q <= `VRD_RST_RDI_TIM_UNEQ;
         rdi_ctrl_lop_ais_q <= `VRD_RST_RDI_LOP_AIS;
         overhead_port_clock_ctrl_q <= `VRD_RST_OH_CLK_CTRL;
      end else begin
         rdi_ctrl_plm_q <= rdi_ctrl_plm_d;
         rdi_ctrl_tim_uneq_q <= rdi_ctrl_tim_uneq_d;
         rdi_ctrl_lop_ais_q <= rdi_ctrl_lop_ais_d;
         overhead_port_clock_ctrl_q <= overhead_port_clock_ctrl_d;
      end
   end

   // Read mux; a read in the cycle of a write shows the old value
   always @* begin
      reg_rdata_d = reg_rdata;
      if (reg_rd) begin
         if (sel_payload) begin
            reg_rdata_d = rdi_ctrl_plm_q;
         end else if (sel_tim_uneq) begin
            reg_rdata_d = rdi_ctrl_tim_uneq_q;
         end else if (sel_lop_ais) begin
            reg_rdata_d = rdi_ctrl_lop_ais_q;
         end else if (sel_clk_ctrl) begin
            reg_rdata_d = overhead_port_clock_ctrl_q;
         end else begin
            // Unmapped addresses answer zero
            reg_rdata_d = 8'h00;
         end
      end
   end

   // Read data is registered and holds until the next read
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_rdata_d;
      end
   end

   // Half-period counter on reference ticks; >= copes with a divider
   // lowered while the count is already past it
   always @* begin
      div_cnt_d = div_cnt_q;
      port_clock_d = overhead_port_clock_out;
      if (ref_tick) begin
         if (div_cnt_q >= overhead_clock_divider) begin
            div_cnt_d = 4'h0;
            port_clock_d = ~overhead_port_clock_out;
         end else begin
            div_cnt_d = div_cnt_q + 4'h1;
         end
      end
   end

   // Port clock leaves straight from a flip-flop, so it cannot glitch
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt_q <= 4'h0;
         overhead_port_clock_out <= 1'b0;
      end else begin
         div_cnt_q <= div_cnt_d;
         overhead_port_clock_out <= port_clock_d;
      end
   end

   // Two-entry buffer: head drives the outputs, skid catches the word
   // accepted in the cycle the receiver stalls, so none is lost.
   // Ready is registered, which costs the skid entry but keeps the
   // upstream path free of a combinational loop through out_ready.
   always @* begin
      head_data_d = out_data;
      head_g1_d = out_g1;
      head_valid_d = out_valid;
      skid_data_d = skid_data_q;
      skid_g1_d = skid_g1_q;
      skid_valid_d = skid_valid_q;
      in_ready_d = in_ready;
      if (!out_valid || out_ready) begin
         // Head drains or is empty: refill it, skid first
         in_ready_d = 1'b1;
         if (skid_valid_q) begin
            head_data_d = skid_data_q;
            head_g1_d = skid_g1_q;
            head_valid_d = 1'b1;
            skid_valid_d = 1'b0;
         end else begin
            head_data_d = ins_data;
            head_g1_d = in_g1;
            head_valid_d = in_fire;
         end
      end else if (in_fire) begin
         // Head stalled: park the word and close the input
         skid_data_d = ins_data;
         skid_g1_d = in_g1;
         skid_valid_d = 1'b1;
         in_ready_d = 1'b0;
      end
   end

   // Buffer flip-flops; input stays closed through reset
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         out_data <= {DATA_W{1'b0}};
         out_g1 <= 1'b0;
         out_valid <= 1'b0;
         skid_data_q <= {DATA_W{1'b0}};
         skid_g1_q <= 1'b0;
         skid_valid_q <= 1'b0;
         in_ready <= 1'b0;
      end else begin
         out_data <= head_data_d;
         out_g1 <= head_g1_d;
         out_valid <= head_valid_d;
         skid_data_q <= skid_data_d;
         skid_g1_q <= skid_g1_d;
         skid_valid_q <= skid_valid_d;
         in_ready <= in_ready_d;
      end
   end

endmodule

// File: dv/vrd_path_rdi_insert_ctrl_properties.sv
`timescale 1ns/1ps
`include "vrd_consts.vh"
module vrd_rdi_properties #(parameter DATA_W = 8) (
   input wire clk, reset_n, reg_rd, ref_tick, overhead_port_clock_out,
   input wire [7:0] reg_addr, reg_rdata,
   input wire [DATA_W-1:0] in_data, out_data,
   input wire in_g1, in_valid, in_ready, out_g1, out_valid, out_ready
);
   wire in_fire = in_valid && in_ready;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Taken while the head drains, so the word is on show next cycle
   sequence s_take; in_valid && in_ready && out_ready; endsequence
   sequence s_g1; s_take ##0 in_g1; endsequence
   a_stall_hold: assert property (out_valid && !out_ready |=>
      out_valid && $stable(out_data) && $stable(out_g1)) else $error("lost");
   a_rdata_keep: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("rdata moved");
   a_unmapped_zero: assert property (reg_rd && reg_addr < 8'hC9
      |=> reg_rdata == 8'h00) else $error("unmapped not zero");
   a_upper_zero: assert property (reg_rd && reg_addr == 8'hCF
      |=> reg_rdata[7:4] == 4'h0) else $error("upper bits set");
   a_tick_only: assert property (!ref_tick |=>
      $stable(overhead_port_clock_out)) else $error("clock without tick");
   a_skid_full: assert property (out_valid && !out_ready && in_fire
      |=> !in_ready) else $error("third word taken");
   a_data_pass: assert property (s_take ##0 !in_g1 |=> !out_g1 &&
      out_data == $past(in_data)) else $error("byte altered");
   a_g1_keep: assert property (s_g1 |=> out_g1 &&
      {out_data[7:4], out_data[0]} == $past({in_data[7:4], in_data[0]}))
      else $error("G1 outer bits altered");
endmodule
bind vrd_path_rdi_insert_ctrl vrd_rdi_properties #(.DATA_W(DATA_W))
   u_props (.*);

// File: dv/vrd_far_sink.sv
`timescale 1ns/1ps
// Far receiver: always ready, or one cycle in four when slow
module vrd_far_sink (
   input wire clk,
   input wire reset_n,
   input wire slow,
   output reg out_ready
);
   integer seed = 32'h4cdd;
   // Slow mode stalls long enough to fill the two-entry buffer
   always @(posedge clk or negedge reset_n)
      if (!reset_n)
         out_ready <= 1'b0;
      else
         out_ready <= !slow || $random(seed) % 4 == 0;
endmodule

// File: dv/vrd_path_rdi_insert_ctrl_tb.sv
`timescale 1ns/1ps
`include "vrd_consts.vh"
`define CK(n, e, g) begin \
   n_compared++; \
   if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("MISMATCH %s exp %h got %h", n, e, g); \
   end \
end
module vrd_path_rdi_insert_ctrl_tb;
   logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, ref_tick = 0;
   logic in_g1 = 0, in_valid = 0, slow = 0, run = 0, tk_en = 0, ohp = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, in_data = 0, df = 0;
   logic [7:0] c9 = 8'h00, ca = 8'hC0, cb = 8'hC0, reg_rdata, out_data;
   logic in_ready, out_g1, out_valid, out_ready, overhead_port_clock_out;
   integer seed = 32'h4cdd, n_mismatch = 0, n_compared = 0, tk = 0, d, i;
   logic [8:0] ex, q[$];
   vrd_path_rdi_insert_ctrl uut (.*, .def_pointer_loss(df[0]),
      .def_path_alarm(df[1]), .def_unequipped(df[2]),
      .def_trace_mismatch(df[3]), .def_payload_mismatch(df[4]));
   vrd_far_sink sink (.*);
   // Fixed priority: first enabled and declared defect wins
   function automatic [2:0] exp_rdi(input [7:0] f);
      exp_rdi = (f[0] & cb[4]) ? cb[7:5] : (f[1] & cb[0]) ? cb[3:1] :
         (f[2] & ca[0]) ? ca[3:1] : (f[3] & ca[4]) ? ca[7:5] :
         (f[4] & c9[0]) ? c9[3:1] : 3'h0;
   endfunction
   function automatic [7:0] rb();
      rb = $random(seed);
   endfunction
   initial forever #5 clk = ~clk;
   // Far beyond the run's length, so only a hang trips it
   initial begin
      #300000;
      n_mismatch++;
      stop_test;
   end
   // Reference ticks and random words; a word holds until taken
   always @(posedge clk) begin
      ref_tick <= tk_en & ~ref_tick;
      if (!in_valid || in_ready) begin
         in_valid <= run && rb() < 8'hB0;
         in_data <= rb();
         in_g1 <= rb() < 8'h60;
         df <= rb();
      end
   end
   // Scoreboard, register shadow and port clock half periods
   always @(posedge clk) if (reset_n) begin
      if (in_valid && in_ready)
         q.push_back({in_g1, in_g1 ?
            {in_data[7:4], exp_rdi(df), in_data[0]} : in_data});
      if (out_valid && out_ready) begin
         ex = q.pop_front();
         `CK("out_data", ex[7:0], out_data)
         `CK("out_g1", ex[8], out_g1)
      end
      if (reg_wr && reg_addr == 8'hC9) c9 <= reg_wdata & 8'h0F;
      if (reg_wr && reg_addr == 8'hCA) ca <= reg_wdata;
      if (reg_wr && reg_addr == 8'hCB) cb <= reg_wdata;
      tk <= tk + ref_tick;
      ohp <= overhead_port_clock_out;
      if (overhead_port_clock_out !== ohp) begin
         `CK("ticks", d + 1, tk)
         tk <= ref_tick;
      end
   end
   task automatic wr(input [7:0] a, input [7:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1;
      @(posedge clk);
      reg_wr <= 0;
      @(posedge clk);
   endtask
   task automatic rd(input [7:0] a, input [7:0] e);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge clk);
      reg_rd <= 0;
      #1 `CK("reg_rdata", e, reg_rdata)
      @(posedge clk);
   endtask
   task automatic stop_test;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Defaults and masks first, then random insertion traffic
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1;
      @(posedge clk);
      rd(8'hC9, 8'h00);
      rd(8'hCA, 8'hC0);
      rd(8'hCB, 8'hC0);
      rd(8'hCF, 8'h00);
      rd(8'h00, 8'h00);
      wr(8'hC9, 8'hFF);
      rd(8'hC9, 8'h0F);
      d = rb() & 8'h0F;
      wr(8'hCF, 8'hF0 | d[7:0]);
      rd(8'hCF, d[7:0]);
      $display("registers done");
      tk_en <= 1;
      run <= 1;
      for (i = 0; i < 60; i++) begin
         slow <= i[1];
         wr(8'hCA, i < 4 ? 8'h00 : rb());
         wr(8'hCB, i < 4 ? 8'h00 : rb());
         wr(8'hC9, i < 4 ? 8'h00 : rb());
         repeat (12) @(posedge clk);
      end
      run <= 0;
      slow <= 0;
      repeat (20) @(posedge clk);
      `CK("words_left", 0, q.size())
      $display("stream done");
      stop_test;
   end
endmodule
